// [dv/sadc_analog_model.sv]
// analog front end model answering the converter's comparator
`timescale 1ns/1ns
module sadc_analog_model #(
	// pga input and gain are settled before any run, so its output is fixed
	parameter logic [11:0] PGA_LVL = 12'hC00,
	parameter logic [11:0] OPAMP_LVL = 12'h555
) (
	// clock
	input wire logic clk_i,
	// switch controls
	input wire logic power_i,
	input wire logic [10:0] chan_i,
	input wire logic [7:0] int_src_i,
	input wire logic [11:0] dac_code_i,
	// comparator
	output logic comparator_o
);
	localparam logic [11:0] INT_LVL [8] = '{12'hFFF, 12'h7FF, 12'h3FF, PGA_LVL,
		PGA_LVL >> 1, PGA_LVL >> 2, OPAMP_LVL, 12'h000};
	logic [11:0] level;
	logic found;
	logic wobble = 1'b0;

	// a floating input has no steady level, so the answer toggles
	always @(posedge clk_i) wobble <= ~wobble;

	// channel n sits at n in the top nibble, internal taps at fixed levels
	always_comb begin
		level = 12'h000;
		found = 1'b0;
		for (int n = 0; n < 11; n++) begin
			if (chan_i[n]) begin
				level = {4'(n), 8'h23};
				found = 1'b1;
			end
		end
		for (int k = 0; k < 8; k++) begin
			if (int_src_i[k]) begin
				level = INT_LVL[k];
				found = 1'b1;
			end
		end
	end

	// unpowered: no reliable decision either
	assign comparator_o = (found && power_i) ? (level >= dac_code_i) : wobble;
endmodule : sadc_analog_model

// [dv/sadc_seq_ctrl_test.sv]
// self-checking bench for the converter sequencer control
`timescale 1ns/1ns
module sadc_seq_ctrl_test;
	logic clk_i = 1'b0;
	logic reset_n = 1'b0;
	logic start = 1'b0;
	logic power_en = 1'b0;
	logic justify = 1'b0;
	logic [3:0] ch_sel = 4'h0;
	logic [3:0] src_sel = 4'h0;
	logic [2:0] div_sel = 3'h0;
	logic [1:0] ref_sel = 2'h0;
	logic [10:0] pin_mode = 11'h000;
	logic conv_ie = 1'b0;
	logic global_ie = 1'b0;
	logic flag_clr = 1'b0;
	logic comparator, busy, irq_flag, irq, power, sample;
	logic [7:0] res_hi, res_lo, int_src;
	logic [11:0] dac;
	logic [10:0] chan, pin_an;
	logic [2:0] ref_con;
	int errors = 0;
	int n_checks = 0;

	// 125 MHz system clock
	always #4 clk_i = ~clk_i;

	sadc_seq_ctrl dut (
		.clk_i(clk_i),
		.reset_n_i(reset_n),
		.start_ctrl_i(start),
		.converter_power_enable_i(power_en),
		.result_justify_select_i(justify),
		.external_channel_select_i(ch_sel),
		.input_source_select_i(src_sel),
		.conv_clock_divider_select_i(div_sel),
		.reference_source_select_i(ref_sel),
		.pin_analog_mode_i(pin_mode),
		.conv_interrupt_enable_i(conv_ie),
		.global_interrupt_enable_i(global_ie),
		.irq_flag_clear_i(flag_clr),
		.comparator_i(comparator),
		.conv_busy_flag_o(busy),
		.result_high_reg_o(res_hi),
		.result_low_reg_o(res_lo),
		.conv_irq_flag_o(irq_flag),
		.conv_irq_o(irq),
		.converter_power_o(power),
		.sample_switch_o(sample),
		.dac_code_o(dac),
		.chan_connect_o(chan),
		.int_src_connect_o(int_src),
		.ref_connect_o(ref_con),
		.pin_analog_o(pin_an)
	);

	sadc_analog_model far (
		.clk_i(clk_i),
		.power_i(power),
		.chan_i(chan),
		.int_src_i(int_src),
		.dac_code_i(dac),
		.comparator_o(comparator)
	);

	// inputs always move 1 ns after the rising edge
	task automatic step();
		@(posedge clk_i);
		#1;
	endtask : step

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			errors++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	task automatic summarize();
		$display("errors=%0d n_checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	// internal sources: {one-hot switch, level}; zero switch means external
	function automatic logic [19:0] src_info(input logic [3:0] src, input logic [3:0] ch);
		case (src)
			4'h1: return {8'h01, 12'hFFF};
			4'h2: return {8'h02, 12'h7FF};
			4'h3: return {8'h04, 12'h3FF};
			4'h5: return {8'h08, 12'hC00};
			4'h6: return {8'h10, 12'h600};
			4'h7: return {8'h20, 12'h300};
			4'h8: return {8'h40, 12'h555};
			4'h9, 4'hA, 4'hB: return {8'h80, 12'h000};
			default: return {8'h00, ch, 8'h23};
		endcase
	endfunction : src_info

	// one conversion; poke pulses start mid-run, which must not restart it
	task automatic convert(input logic [2:0] sel, input logic [3:0] src, input logic [3:0] ch,
		input logic just, input bit poke);
		int div;
		int nb;
		int ns;
		logic [19:0] info;
		div = 1 << sel;
		nb = 0;
		ns = 0;
		info = src_info(src, ch);
		div_sel = sel;
		src_sel = src;
		ch_sel = ch;
		justify = just;
		flag_clr = 1'b1;
		repeat (2) step();
		flag_clr = 1'b0;
		start = 1'b1;
		step();
		start = 1'b0;
		for (int i = 0; i < 4 && busy !== 1'b1; i++) step();
		check(busy, 1'b1);
		check(irq_flag, 1'b0);
		while (busy === 1'b1 && nb < 2100) begin
			nb++;
			if (sample === 1'b1) ns++;
			start = poke && (nb == 20);
			step();
		end
		check(nb >= 16 * div - 1 && nb <= 16 * div + 2, 1'b1);
		check(ns >= 4 * div - 1 && ns <= 4 * div + 1, 1'b1);
		check(irq_flag, 1'b1);
		// slow clocks only: the two fastest divisions may decide late
		if (sel >= 3'h2 && (info[19:12] != 8'h00 || ch <= 4'hA)) begin
			check(res_hi, just ? {4'h0, info[11:8]} : info[11:4]);
			check(res_lo, just ? info[7:0] : {info[3:0], 4'h0});
		end
	endtask : convert

	// watchdog well beyond the expected run length
	initial begin
		#200000;
		errors++;
		summarize();
	end

	initial begin
		logic [10:0] pins [3];
		logic [19:0] info;
		pins = '{11'h000, 11'h555, 11'h7FF};
		repeat (16) step();
		check(busy, 1'b0);
		check(res_hi, 8'h00);
		check(res_lo, 8'h00);
		check(ref_con, 3'h1);
		check(chan, 11'h000);
		reset_n = 1'b1;
		repeat (4) step();
		for (int r = 0; r < 4; r++) begin
			ref_sel = 2'(r);
			repeat (2) step();
			check(ref_con, r >= 2 ? 3'h4 : (r == 1 ? 3'h2 : 3'h1));
		end
		foreach (pins[i]) begin
			pin_mode = pins[i];
			repeat (2) step();
			check(pin_an, pins[i]);
		end
		// every source code against every channel code
		for (int s = 0; s < 16; s++) begin
			for (int c = 0; c < 16; c++) begin
				src_sel = 4'(s);
				ch_sel = 4'(c);
				info = src_info(src_sel, ch_sel);
				repeat (2) step();
				check(chan, (info[19:12] == 8'h00 && c <= 10) ? 11'h001 << c : 11'h000);
				check(int_src, info[19:12]);
			end
		end
		// start held high, then dropped while disabled: nothing may start
		power_en = 1'b1;
		repeat (8) step();
		start = 1'b1;
		repeat (30) step();
		check(busy, 1'b0);
		power_en = 1'b0;
		step();
		start = 1'b0;
		repeat (4) step();
		check(busy, 1'b0);
		check(power, 1'b0);
		power_en = 1'b1;
		repeat (8) step();
		check(power, 1'b1);
		pin_mode = 11'h7FF;
		convert(3'h6, 4'h0, 4'h5, 1'b0, 1'b0);
		convert(3'h2, 4'hC, 4'hA, 1'b1, 1'b1);
		convert(3'h4, 4'h4, 4'hC, 1'b0, 1'b0);
		convert(3'h0, 4'hF, 4'h1, 1'b1, 1'b0);
		convert(3'h1, 4'hD, 4'h3, 1'b0, 1'b0);
		convert(3'h7, 4'hE, 4'h0, 1'b1, 1'b0);
		for (int s = 1; s < 12; s++) begin
			if (s != 4) convert(3'h3, 4'(s), 4'h2, s[0], 1'b0);
		end
		convert(3'h5, 4'h8, 4'h7, 1'b0, 1'b0);
		for (int e = 0; e < 4; e++) begin
			conv_ie = e[0];
			global_ie = e[1];
			repeat (2) step();
			check(irq, e == 3);
		end
		flag_clr = 1'b1;
		step();
		flag_clr = 1'b0;
		step();
		check(irq_flag, 1'b0);
		check(irq, 1'b0);
		// abort mid-run: busy drops, no request, results kept
		start = 1'b1;
		step();
		start = 1'b0;
		repeat (40) step();
		check(busy, 1'b1);
		power_en = 1'b0;
		repeat (3) step();
		check(busy, 1'b0);
		check(irq_flag, 1'b0);
		check(res_hi, 8'h55);
		check(res_lo, 8'h50);
		summarize();
	end
endmodule : sadc_seq_ctrl_test

// [rtl/sadc_clk_div.sv]
// converter clock divider, one-cycle tick at clk / 2**sel
`timescale 1ns/1ns
module sadc_clk_div #(
	parameter int SEL_W = sadc_pkg::DIV_SEL_W,
	parameter int CNT_W = sadc_pkg::DIV_CNT_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic run_i,
	input wire logic [SEL_W-1:0] div_sel_i,
	// converter clock enable
	output logic tick_o
);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] limit;

	// divisor doubles with each code step
	assign limit = CNT_W'((1 << div_sel_i) - 1);

	// counter restarts whenever the sequencer is idle, so phases align to start
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= '0;
		end else if (!run_i || cnt_ff >= limit) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + CNT_W'(1);
		end
	end

	// registered tick
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= run_i && (cnt_ff >= limit);
		end
	end

	a_div_one_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(run_i && div_sel_i == '0) ##1 (run_i && div_sel_i == '0) |=> tick_o)
		else $error("undivided converter clock missed a tick");

	a_div_two_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(tick_o && div_sel_i == SEL_W'(1) && $stable(div_sel_i)) |=> !tick_o)
		else $error("divide-by-two ticks back to back");

endmodule : sadc_clk_div

// [rtl/sadc_input_route.sv]
// registered decode of input source, channel, reference and pin mode
`timescale 1ns/1ns
module sadc_input_route #(
	parameter int CHANS = sadc_pkg::CHAN_COUNT
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// selections
	input wire logic [3:0] input_source_select_i,
	input wire logic [3:0] external_channel_select_i,
	input wire logic [1:0] reference_source_select_i,
	input wire logic [CHANS-1:0] pin_analog_mode_i,
	// analog switch controls
	output logic [CHANS-1:0] chan_connect_o,
	output logic [sadc_pkg::INT_SRC_COUNT-1:0] int_src_connect_o,
	output logic [2:0] ref_connect_o,
	output logic [CHANS-1:0] pin_analog_o
);

	logic src_is_internal;
	logic [7:0] nxt_int_src;

	// internal source one-hot decode
	always_comb begin
		nxt_int_src = '0;
		unique case (input_source_select_i)
			sadc_pkg::SRC_VDD: nxt_int_src[sadc_pkg::ISRC_VDD] = 1'b1;
			sadc_pkg::SRC_VDD_DIV2: nxt_int_src[sadc_pkg::ISRC_VDD_DIV2] = 1'b1;
			sadc_pkg::SRC_VDD_DIV4: nxt_int_src[sadc_pkg::ISRC_VDD_DIV4] = 1'b1;
			sadc_pkg::SRC_PGA: nxt_int_src[sadc_pkg::ISRC_PGA] = 1'b1;
			sadc_pkg::SRC_PGA_DIV2: nxt_int_src[sadc_pkg::ISRC_PGA_DIV2] = 1'b1;
			sadc_pkg::SRC_PGA_DIV4: nxt_int_src[sadc_pkg::ISRC_PGA_DIV4] = 1'b1;
			sadc_pkg::SRC_OPAMP: nxt_int_src[sadc_pkg::ISRC_OPAMP] = 1'b1;
			default: begin
				// ground codes; 0000, 0100 and 11xx leave everything clear
				if (input_source_select_i >= sadc_pkg::SRC_GND_LO &&
					input_source_select_i <= sadc_pkg::SRC_GND_HI) begin
					nxt_int_src[sadc_pkg::ISRC_GND] = 1'b1;
				end
			end
		endcase
	end

	assign src_is_internal = |nxt_int_src;

	// one switch per external channel; unused codes leave the input floating
	genvar ch;
	generate
		for (ch = 0; ch < CHANS; ch++) begin : g_chan
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					chan_connect_o[ch] <= 1'b0;
				end else begin
					chan_connect_o[ch] <= !src_is_internal &&
						(external_channel_select_i == 4'(ch));
				end
			end
		end
	endgenerate

	// internal source, reference and pin mode switches
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			int_src_connect_o <= '0;
			ref_connect_o <= 3'h1;
			pin_analog_o <= '0;
		end else begin
			int_src_connect_o <= nxt_int_src;
			ref_connect_o[0] <= reference_source_select_i == sadc_pkg::REF_SUPPLY;
			ref_connect_o[1] <= reference_source_select_i == sadc_pkg::REF_EXT_PIN;
			ref_connect_o[2] <= reference_source_select_i[1];
			pin_analog_o <= pin_analog_mode_i;
		end
	end

	a_internal_isolate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(|int_src_connect_o) |-> (chan_connect_o == '0))
		else $error("external channel connected with internal source");

	a_floating_chan: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!src_is_internal && external_channel_select_i > 4'hA) |=> chan_connect_o == '0)
		else $error("nonexistent channel code connected a pin");

	a_ref_pga: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		reference_source_select_i[1] |=> (ref_connect_o == 3'h4))
		else $error("pga reference not selected alone");

endmodule : sadc_input_route

// [rtl/sadc_pkg.sv]
// shared constants and types for the converter sequencer control
package sadc_pkg;

	// converter geometry
	localparam int RESULT_W = 12;
	localparam int CHAN_COUNT = 11;
	localparam int CHAN_SEL_W = 4;
	localparam int SRC_SEL_W = 4;
	localparam int DIV_SEL_W = 3;
	localparam int DIV_CNT_W = 7;
	localparam int INT_SRC_COUNT = 8;

	// conversion phases, in converter clocks
	localparam logic [3:0] SAMPLE_CLKS = 4'h4;
	localparam logic [3:0] CONVERT_CLKS = 4'hC;
	localparam logic [3:0] TOTAL_CLKS_M1 = 4'hF;

	// reference select codes, upper bit set means pga output
	localparam logic [1:0] REF_SUPPLY = 2'h0;
	localparam logic [1:0] REF_EXT_PIN = 2'h1;

	// input source codes that pick an internal signal
	localparam logic [3:0] SRC_VDD = 4'h1;
	localparam logic [3:0] SRC_VDD_DIV2 = 4'h2;
	localparam logic [3:0] SRC_VDD_DIV4 = 4'h3;
	localparam logic [3:0] SRC_PGA = 4'h5;
	localparam logic [3:0] SRC_PGA_DIV2 = 4'h6;
	localparam logic [3:0] SRC_PGA_DIV4 = 4'h7;
	localparam logic [3:0] SRC_OPAMP = 4'h8;
	localparam logic [3:0] SRC_GND_LO = 4'h9;
	localparam logic [3:0] SRC_GND_HI = 4'hB;

	// index of each internal source in the one-hot select
	localparam int ISRC_VDD = 0;
	localparam int ISRC_VDD_DIV2 = 1;
	localparam int ISRC_VDD_DIV4 = 2;
	localparam int ISRC_PGA = 3;
	localparam int ISRC_PGA_DIV2 = 4;
	localparam int ISRC_PGA_DIV4 = 5;
	localparam int ISRC_OPAMP = 6;
	localparam int ISRC_GND = 7;

	// first sar trial code, msb set
	localparam logic [11:0] SAR_FIRST = 12'h800;
	localparam logic [3:0] SAR_MSB_IDX = 4'hB;

	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONVERT = 3'b100
	} sadc_state_t;

endpackage : sadc_pkg

// [rtl/sadc_seq_ctrl.sv]
// converter sequencer control top: start detect, sar sequence, results, irq
//
// Summary of operation
// - reference select 00 supply, 01 external pin, 1x pga output.
// - analog pin mode disables pin function, pull-high and direction.
// - source codes 0000, 0100, 11xx pick an external channel.
// - channel codes 0..10 connect channels 0..10; 11..15 float.
// - internal source codes map to supply, pga, op-amp or ground taps.
// - any internal source disconnects every external channel.
// - conversion starts only on start bit high then low.
// - completion sets request flag; irq only when both enables set.
// - clock select divides system clock by 2**code, 1 to 128.
// - four sampling clocks then twelve converting clocks, sixteen total.
// - converter powered only while enable bit high; clearing stops it.
// - format bit 0 left-justifies, 1 right-justifies the twelve-bit result.
// - clearing enable leaves both result registers unchanged.
`timescale 1ns/1ns
module sadc_seq_ctrl #(
	parameter int CHANS = sadc_pkg::CHAN_COUNT
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// control bits from software
	input wire logic start_ctrl_i,
	input wire logic converter_power_enable_i,
	input wire logic result_justify_select_i,
	input wire logic [3:0] external_channel_select_i,
	input wire logic [3:0] input_source_select_i,
	input wire logic [2:0] conv_clock_divider_select_i,
	input wire logic [1:0] reference_source_select_i,
	input wire logic [CHANS-1:0] pin_analog_mode_i,
	// interrupt control from software
	input wire logic conv_interrupt_enable_i,
	input wire logic global_interrupt_enable_i,
	input wire logic irq_flag_clear_i,
	// comparator from the analog core
	input wire logic comparator_i,
	// status and results
	output logic conv_busy_flag_o,
	output logic [7:0] result_high_reg_o,
	output logic [7:0] result_low_reg_o,
	output logic conv_irq_flag_o,
	output logic conv_irq_o,
	// analog core controls
	output logic converter_power_o,
	output logic sample_switch_o,
	output logic [11:0] dac_code_o,
	output logic [CHANS-1:0] chan_connect_o,
	output logic [7:0] int_src_connect_o,
	output logic [2:0] ref_connect_o,
	output logic [CHANS-1:0] pin_analog_o
);

	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic comp_meta_ff;
	logic comp_sync_ff;
	logic start_prev_ff;
	logic start_fall;
	logic conv_go;
	logic conv_tick;
	logic conv_done;
	logic busy_ff;
	logic power_ff;
	sadc_pkg::sadc_state_t state_ff;
	sadc_pkg::sadc_state_t nxt_state;
	logic [3:0] phase_cnt_ff;
	logic [3:0] bit_idx_ff;
	logic [11:0] sar_ff;
	logic [11:0] nxt_sar;
	logic [11:0] final_code;
	logic [7:0] result_high_ff;
	logic [7:0] result_low_ff;
	logic irq_flag_ff;
	logic nxt_irq_flag;
	logic irq_ff;
	logic [3:0] ticks_seen_ff;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// comparator is analog and asynchronous to clk; two-flop sync
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			comp_meta_ff <= 1'b0;
			comp_sync_ff <= 1'b0;
		end else begin
			comp_meta_ff <= comparator_i;
			comp_sync_ff <= comp_meta_ff;
		end
	end

	// start bit history; a level alone never starts anything
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			start_prev_ff <= 1'b0;
		end else begin
			start_prev_ff <= start_ctrl_i;
		end
	end

	assign start_fall = start_prev_ff && !start_ctrl_i;
	// a pulse while busy or powered down is dropped, not queued
	assign conv_go = start_fall && converter_power_enable_i && !busy_ff;

	// converter power follows the enable bit
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			power_ff <= 1'b0;
		end else begin
			power_ff <= converter_power_enable_i;
		end
	end

	// converter clock enable, runs only during a conversion
	sadc_clk_div #(
		.SEL_W(sadc_pkg::DIV_SEL_W),
		.CNT_W(sadc_pkg::DIV_CNT_W)
	) u_clk_div (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.run_i(busy_ff),
		.div_sel_i(conv_clock_divider_select_i),
		.tick_o(conv_tick)
	);

	// input, channel, reference and pin-mode switches
	sadc_input_route #(
		.CHANS(CHANS)
	) u_route (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.input_source_select_i(input_source_select_i),
		.external_channel_select_i(external_channel_select_i),
		.reference_source_select_i(reference_source_select_i),
		.pin_analog_mode_i(pin_analog_mode_i),
		.chan_connect_o(chan_connect_o),
		.int_src_connect_o(int_src_connect_o),
		.ref_connect_o(ref_connect_o),
		.pin_analog_o(pin_analog_o)
	);

	assign conv_done = (state_ff == sadc_pkg::ST_CONVERT) && conv_tick &&
		(bit_idx_ff == 4'h0) && converter_power_enable_i;

	// sequencer next state
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			sadc_pkg::ST_IDLE: begin
				if (conv_go) begin
					nxt_state = sadc_pkg::ST_SAMPLE;
				end
			end
			sadc_pkg::ST_SAMPLE: begin
				if (!converter_power_enable_i) begin
					nxt_state = sadc_pkg::ST_IDLE;
				end else if (conv_tick && phase_cnt_ff == sadc_pkg::SAMPLE_CLKS - 4'h1) begin
					nxt_state = sadc_pkg::ST_CONVERT;
				end
			end
			sadc_pkg::ST_CONVERT: begin
				if (!converter_power_enable_i || conv_done) begin
					nxt_state = sadc_pkg::ST_IDLE;
				end
			end
			default: nxt_state = sadc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= sadc_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// sampling clock counter
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			phase_cnt_ff <= 4'h0;
		end else if (state_ff != sadc_pkg::ST_SAMPLE) begin
			phase_cnt_ff <= 4'h0;
		end else if (conv_tick) begin
			phase_cnt_ff <= phase_cnt_ff + 4'h1;
		end
	end

	// sar trial: keep the bit if input is at or above the dac level
	always_comb begin
		nxt_sar = sar_ff;
		if (!comp_sync_ff) begin
			nxt_sar[bit_idx_ff] = 1'b0;
		end
		if (bit_idx_ff != 4'h0) begin
			nxt_sar[bit_idx_ff - 4'h1] = 1'b1;
		end
	end

	// comparator passes two sync flops, so very fast converter clocks
	// resolve on a stale decision; divider codes 0 and 1 are not blocked and can give wrong results
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sar_ff <= 12'h000;
			bit_idx_ff <= 4'h0;
		end else if (state_ff == sadc_pkg::ST_SAMPLE && nxt_state == sadc_pkg::ST_CONVERT) begin
			sar_ff <= sadc_pkg::SAR_FIRST;
			bit_idx_ff <= sadc_pkg::SAR_MSB_IDX;
		end else if (state_ff == sadc_pkg::ST_CONVERT && conv_tick) begin
			sar_ff <= nxt_sar;
			bit_idx_ff <= bit_idx_ff - 4'h1;
		end
	end

	// busy flag
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
		end else if (conv_go) begin
			busy_ff <= 1'b1;
		end else if (conv_done || !converter_power_enable_i) begin
			busy_ff <= 1'b0;
		end
	end

	// final code includes the last bit decision
	assign final_code = nxt_sar;

	// result registers, loaded only by a finished conversion
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			result_high_ff <= 8'h00;
			result_low_ff <= 8'h00;
		end else if (conv_done) begin
			if (result_justify_select_i) begin
				result_high_ff <= {4'h0, final_code[11:8]};
				result_low_ff <= final_code[7:0];
			end else begin
				result_high_ff <= final_code[11:4];
				result_low_ff <= {final_code[3:0], 4'h0};
			end
		end
	end

	// request flag: completion wins over a clear in the same cycle
	assign nxt_irq_flag = conv_done || (irq_flag_ff && !irq_flag_clear_i);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_flag_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			irq_flag_ff <= nxt_irq_flag;
			irq_ff <= nxt_irq_flag && conv_interrupt_enable_i && global_interrupt_enable_i;
		end
	end

	// checking aid: converter clocks seen since start
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ticks_seen_ff <= 4'h0;
		end else if (conv_go) begin
			ticks_seen_ff <= 4'h0;
		end else if (busy_ff && conv_tick) begin
			ticks_seen_ff <= ticks_seen_ff + 4'h1;
		end
	end

	// outputs straight from flops
	assign conv_busy_flag_o = busy_ff;
	assign result_high_reg_o = result_high_ff;
	assign result_low_reg_o = result_low_ff;
	assign conv_irq_flag_o = irq_flag_ff;
	assign conv_irq_o = irq_ff;
	assign converter_power_o = power_ff;
	assign sample_switch_o = state_ff[1];
	assign dac_code_o = sar_ff;

	a_start_sets_busy: assert property (@(posedge clk_i) disable iff (!rst_n)
		(start_prev_ff && !start_ctrl_i && converter_power_enable_i && !busy_ff)
		|=> busy_ff ##1 sample_switch_o)
		else $error("start pulse did not begin a conversion");

	a_level_no_start: assert property (@(posedge clk_i) disable iff (!rst_n)
		(!busy_ff && !(start_prev_ff && !start_ctrl_i)) |=> !busy_ff)
		else $error("conversion began without a high-low start pulse");

	a_sixteen_clocks: assert property (@(posedge clk_i) disable iff (!rst_n)
		conv_done |-> ticks_seen_ff == sadc_pkg::TOTAL_CLKS_M1)
		else $error("conversion did not take sixteen converter clocks");

	a_done_same_cycle: assert property (@(posedge clk_i) disable iff (!rst_n)
		conv_done |=> (!busy_ff && irq_flag_ff && ($past(result_justify_select_i) ?
		{result_high_ff[3:0], result_low_ff} : {result_high_ff, result_low_ff[7:4]}) ==
		$past(final_code)))
		else $error("busy, flag and result not updated together");

	a_busy_till_done: assert property (@(posedge clk_i) disable iff (!rst_n)
		(busy_ff && !conv_done && converter_power_enable_i) |=> busy_ff)
		else $error("busy dropped before completion");

	a_power_off_stop: assert property (@(posedge clk_i) disable iff (!rst_n)
		!converter_power_enable_i |=> (!busy_ff && !power_ff && state_ff == sadc_pkg::ST_IDLE))
		else $error("converter kept running while disabled");

	a_result_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
		(!converter_power_enable_i ##1 !converter_power_enable_i)
		|=> ($stable(result_high_ff) && $stable(result_low_ff)))
		else $error("results changed while converter disabled");

	a_right_justify: assert property (@(posedge clk_i) disable iff (!rst_n)
		(conv_done && result_justify_select_i) |=> result_high_ff[7:4] == 4'h0)
		else $error("right-justified high byte has upper bits set");

	a_left_justify: assert property (@(posedge clk_i) disable iff (!rst_n)
		(conv_done && !result_justify_select_i) |=> result_low_ff[3:0] == 4'h0)
		else $error("left-justified low byte has lower bits set");

	a_irq_gated: assert property (@(posedge clk_i) disable iff (!rst_n)
		conv_irq_o |-> (irq_flag_ff && $past(conv_interrupt_enable_i) &&
			$past(global_interrupt_enable_i)))
		else $error("interrupt raised without flag or enables");

	a_flag_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n)
		(conv_done && irq_flag_clear_i) |=> irq_flag_ff)
		else $error("completion lost against a flag clear");

endmodule : sadc_seq_ctrl
